// file: common/awr_pkg.sv
// Shared constants and types for the converter host sequencer
package awr_pkg;
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CODE_COUNT = 256;
  localparam int unsigned LSB_UV = 19500;
  localparam logic [7:0] BIPOLAR_OFFSET = 8'h80;
  localparam int unsigned SAMPLE_RATE_KHZ = 1000;
  localparam int unsigned MIN_START_NS = 1000000 / SAMPLE_RATE_KHZ;
  localparam int unsigned MIN_START_CYC = (MIN_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MUX_CHANNELS = 16;
  localparam int unsigned CHAN_RATE_KHZ = 16;
  localparam int unsigned CHAN_PERIOD_NS = 1000000 / CHAN_RATE_KHZ;
  localparam int unsigned CHAN_PERIOD_CYC = (CHAN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STROBE_NS = 100;
  localparam int unsigned STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 16;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WRITE = 3'b001,
    ST_WAIT = 3'b010,
    ST_READ = 3'b011,
    ST_RECOVER = 3'b100
  } awr_state_t;

  typedef struct packed {
    logic csN;
    logic wrN;
    logic rdN;
    logic modeSel;
  } awr_pins_t;
endpackage

// file: rtl/awr_host_sequencer.sv
// Host sequencer driving the converter port in write-then-read mode with a capture FIFO
// Functional notes
// - Each conversion starts with a write access
// - Result read separately, after conversion finishes
// - Leave service time between starts
// - Done triggers chip select, read, FIFO push, or the overflow flag when full
// - Polling: sample done line until low
// - Starts paced by precise periodic timer
// - Starts no faster than 1 MHz rate
// - Sixteen mux channels, each at most 16 kHz
// - Hold mode select high for write-read mode
// - Write strobe low under chip select starts
`timescale 1ns/10ps
module awr_host_sequencer #(
  parameter int unsigned FIFO_DEPTH = 16,
  parameter int unsigned PERIOD_CYC = awr_pkg::CHAN_PERIOD_CYC / awr_pkg::MUX_CHANNELS,
  parameter int unsigned MUX_W = 4
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic bipolar,
  input wire logic doneN,
  input wire logic [7:0] result_bus,
  output logic csN,
  output logic wrN,
  output logic rdN,
  output logic modeSel,
  output logic [MUX_W-1:0] muxChan,
  input wire logic popReq,
  output logic popValid,
  output logic [7:0] popData,
  output logic [MUX_W-1:0] popChan,
  output logic fifoEmpty,
  output logic fifoFull,
  output logic overflow,
  input wire logic overflowClr
);
  // Pointers carry one extra bit to tell full from empty
  localparam int unsigned AW = $clog2(FIFO_DEPTH);
  localparam int unsigned ENTRY_W = 8 + MUX_W;
  // Guard the pacing so no PERIOD_CYC up to 65536 can exceed either sample-rate limit with MUX_W of 4 or more
  localparam int unsigned PER_RAW = (PERIOD_CYC < awr_pkg::MIN_START_CYC) ?
      awr_pkg::MIN_START_CYC : PERIOD_CYC;
  localparam int unsigned PER_SAFE = (PER_RAW * awr_pkg::MUX_CHANNELS < awr_pkg::CHAN_PERIOD_CYC) ?
      (awr_pkg::CHAN_PERIOD_CYC + awr_pkg::MUX_CHANNELS - 1) / awr_pkg::MUX_CHANNELS : PER_RAW;
  localparam logic [awr_pkg::CNT_W-1:0] PER_LOAD = awr_pkg::CNT_W'(PER_SAFE - 1);
  localparam logic [awr_pkg::CNT_W-1:0] STB_LOAD = awr_pkg::CNT_W'(awr_pkg::STROBE_CYC - 1);

  // Whole controller state; one register stage, filled by the process below
  typedef struct packed {
    awr_pkg::awr_state_t state;
    awr_pkg::awr_pins_t pins;
    logic [awr_pkg::CNT_W-1:0] timer;
    logic [awr_pkg::CNT_W-1:0] strobe;
    logic [MUX_W-1:0] chan;
    // Channel of the conversion in flight, stored with its result
    logic [MUX_W-1:0] convChan;
    logic [AW:0] wrPtr;
    logic [AW:0] rdPtr;
    logic popValid;
    logic [ENTRY_W-1:0] popEntry;
    logic overflow;
    logic fullFlag;
    logic emptyFlag;
  } awr_regs_t;

  awr_regs_t r;
  awr_regs_t next_r;
  // One entry per sample: channel above, code below
  logic [ENTRY_W-1:0] mem [FIFO_DEPTH];
  logic pushEn;
  logic [ENTRY_W-1:0] pushEntry;
  logic full;
  logic empty;
  logic [7:0] code;

  assign full = (r.wrPtr[AW] != r.rdPtr[AW]) && (r.wrPtr[AW-1:0] == r.rdPtr[AW-1:0]);
  assign empty = r.wrPtr == r.rdPtr;
  // Bipolar offset binary becomes two's complement for the user side
  assign code = bipolar ? (result_bus ^ awr_pkg::BIPOLAR_OFFSET) : result_bus;

  always_comb begin
    next_r = r;
    pushEn = 1'b0;
    pushEntry = {r.convChan, code};
    next_r.pins.modeSel = 1'b1;
    next_r.popValid = 1'b0;

    // Free-running timer keeps sample spacing independent of read latency
    if (r.timer != awr_pkg::CNT_ZERO) begin
      next_r.timer = r.timer - awr_pkg::CNT_ONE;
    end
    if (r.strobe != awr_pkg::CNT_ZERO) begin
      next_r.strobe = r.strobe - awr_pkg::CNT_ONE;
    end
    case (r.state)
      awr_pkg::ST_IDLE: begin
        // Chip select and write strobe fall together on the start edge
        if (enable && r.timer == awr_pkg::CNT_ZERO) begin
          next_r.timer = PER_LOAD;
          next_r.strobe = STB_LOAD;
          next_r.pins.csN = 1'b0;
          next_r.pins.wrN = 1'b0;
          next_r.convChan = r.chan;
          next_r.state = awr_pkg::ST_WRITE;
        end
      end

      awr_pkg::ST_WRITE: begin
        // Channel moves on only once the write ends, so the mux settles before the next start
        if (r.strobe == awr_pkg::CNT_ZERO) begin
          next_r.pins.wrN = 1'b1;
          next_r.pins.csN = 1'b1;
          next_r.chan = r.chan + MUX_W'(1);
          next_r.state = awr_pkg::ST_WAIT;
        end
      end

      awr_pkg::ST_WAIT: begin
        // Done line polled each cycle; missing done is caught by the next start slot
        if (!doneN) begin
          next_r.strobe = STB_LOAD;
          next_r.pins.csN = 1'b0;
          next_r.pins.rdN = 1'b0;
          next_r.state = awr_pkg::ST_READ;
        end else if (r.timer == awr_pkg::CNT_ZERO) begin
          next_r.state = awr_pkg::ST_IDLE;
        end
      end

      awr_pkg::ST_READ: begin
        // Data is taken on the last low cycle of the read strobe, while the bus is driven
        if (r.strobe == awr_pkg::CNT_ZERO) begin
          if (full) begin
            next_r.overflow = 1'b1;
          end else begin
            pushEn = 1'b1;
            next_r.wrPtr = r.wrPtr + (AW+1)'(1);
          end
          next_r.pins.rdN = 1'b1;
          next_r.pins.csN = 1'b1;
          next_r.state = awr_pkg::ST_RECOVER;
        end
      end

      awr_pkg::ST_RECOVER: begin
        // Stays here until done returns high, at least one cycle, before the next poll
        if (doneN) begin
          next_r.state = awr_pkg::ST_IDLE;
        end
      end
      default: begin
        next_r.state = awr_pkg::ST_IDLE;
      end
    endcase

    // Pop is independent of the sequencer, so draining never stalls sampling
    if (popReq && !empty) begin
      next_r.popValid = 1'b1;
      next_r.popEntry = mem[r.rdPtr[AW-1:0]];
      next_r.rdPtr = r.rdPtr + (AW+1)'(1);
    end
    // Set wins over a clear arriving in the same cycle
    if (overflowClr &&
        !(r.state == awr_pkg::ST_READ && r.strobe == awr_pkg::CNT_ZERO && full)) begin
      next_r.overflow = 1'b0;
    end

    // Flags registered with the pointers so both change on the same edge
    next_r.fullFlag = (next_r.wrPtr[AW] != next_r.rdPtr[AW]) &&
        (next_r.wrPtr[AW-1:0] == next_r.rdPtr[AW-1:0]);
    next_r.emptyFlag = next_r.wrPtr == next_r.rdPtr;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      r <= '{
        state: awr_pkg::ST_IDLE,
        pins: 4'hf,
        timer: awr_pkg::CNT_ZERO,
        strobe: awr_pkg::CNT_ZERO,
        chan: '0,
        convChan: '0,
        wrPtr: '0,
        rdPtr: '0,
        popValid: 1'b0,
        popEntry: '0,
        overflow: 1'b0,
        fullFlag: 1'b0,
        emptyFlag: 1'b1
      };
    end else begin
      r <= next_r;
    end
  end

  // Storage has no reset; only the pointers say which entries hold data
  always_ff @(posedge sys_clk) begin
    if (pushEn) begin
      mem[r.wrPtr[AW-1:0]] <= pushEntry;
    end
  end

  // Outputs come straight from the registered state
  assign csN = r.pins.csN;
  assign wrN = r.pins.wrN;
  assign rdN = r.pins.rdN;
  assign modeSel = r.pins.modeSel;
  assign muxChan = r.chan;
  assign popValid = r.popValid;
  assign popData = r.popEntry[7:0];
  assign popChan = r.popEntry[ENTRY_W-1:8];
  assign fifoEmpty = r.emptyFlag;
  assign fifoFull = r.fullFlag;
  assign overflow = r.overflow;
endmodule

// file: tb/awr_conv_model.sv
// Behavioural converter on the host port, write-then-read mode
`timescale 1ns/10ps
module awr_conv_model (
  input wire awr_pkg::awr_pins_t pins,
  input wire logic [7:0] code,
  input wire integer convNs,
  output logic doneN,
  output logic [7:0] result_bus
);
  logic [7:0] held = 8'h00;
  logic [7:0] latched = 8'h00;
  logic busy = 1'b0;
  initial doneN = 1'b1;
  always @(negedge pins.wrN) begin
    if (!pins.csN && pins.modeSel) begin
      busy = 1'b1;
      #50 held = code;
    end
  end
  always @(posedge pins.wrN) begin
    if (busy) begin
      busy = 1'b0;
      #(convNs);
      latched = held;
      doneN = 1'b0;
    end
  end
  always @(posedge pins.rdN or posedge pins.csN) doneN = 1'b1;
  // No pull on the bus, so a released bus shows the inverse of the result
  assign result_bus = (!pins.csN && !pins.rdN) ? latched : ~latched;
endmodule

// file: tb/awr_host_sequencer_sva.sv
// Port checker for the converter host sequencer
`timescale 1ns/10ps
module awr_host_sequencer_sva (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic csN,
  input wire logic wrN,
  input wire logic rdN,
  input wire logic modeSel,
  input wire logic doneN,
  input wire logic popReq,
  input wire logic popValid,
  input wire logic fifoEmpty,
  input wire logic fifoFull,
  input wire logic overflow
);
  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  logic [15:0] gap;
  // Cycles since the last start, saturating so a long idle never wraps
  always_ff @(posedge sys_clk) begin
    if (!rst_n) gap <= 16'hffff;
    else if ($fell(wrN)) gap <= 16'h0000;
    else if (gap != 16'hffff) gap <= gap + 16'h0001;
  end
  AST_MODE: assert property (modeSel) else $error("mode select low");
  AST_WR_CS: assert property (!wrN |-> !csN) else $error("write without select");
  AST_RD_CS: assert property (!rdN |-> !csN && wrN) else $error("bad read");
  AST_WR_LEN: assert property ($fell(wrN) |-> ##24 !wrN ##1 wrN)
    else $error("write strobe length");
  AST_RD_DONE: assert property ($fell(rdN) |-> !$past(doneN))
    else $error("read before done");
  AST_GAP: assert property ($fell(wrN) |-> gap >= 16'h03d0)
    else $error("starts too close");
  AST_POP: assert property (popReq && !fifoEmpty |=> popValid) else $error("no pop");
  AST_NOPOP: assert property (!popReq |=> !popValid) else $error("stray pop");
  AST_FLAGS: assert property (!(fifoEmpty && fifoFull)) else $error("flags");
  AST_OVF: assert property ($rose(overflow) |-> $past(fifoFull))
    else $error("overflow while not full");
endmodule
bind awr_host_sequencer awr_host_sequencer_sva u_sva (.sys_clk(sys_clk), .rst_n(rst_n),
  .csN(csN), .wrN(wrN), .rdN(rdN), .modeSel(modeSel), .doneN(doneN), .popReq(popReq),
  .popValid(popValid), .fifoEmpty(fifoEmpty), .fifoFull(fifoFull), .overflow(overflow));

// file: tb/tb_awr_host_sequencer.sv
// Self-checking bench for the converter host sequencer
`timescale 1ns/10ps
module tb_awr_host_sequencer;
  logic sys_clk = 0, rst_n = 0, enable = 0, bipolar = 0, popReq = 0, overflowClr = 0;
  logic doneN, popValid, fifoEmpty, fifoFull, overflow;
  logic [7:0] result_bus, popData, code = 8'h00;
  logic [3:0] muxChan, popChan, expChan = 4'h0;
  logic [7:0] codes [6] = '{8'h00, 8'hff, 8'h80, 8'h7f, 8'h01, 8'hfe};
  wire awr_pkg::awr_pins_t pins;
  int bad_count = 0, comparisons = 0, convNs = 381;
  always #2 sys_clk = ~sys_clk;
  awr_host_sequencer #(.FIFO_DEPTH(4)) u_awr_host_sequencer (.sys_clk(sys_clk), .rst_n(rst_n),
    .enable(enable), .bipolar(bipolar), .doneN(doneN), .result_bus(result_bus), .csN(pins.csN),
    .wrN(pins.wrN), .rdN(pins.rdN), .modeSel(pins.modeSel), .muxChan(muxChan), .popReq(popReq),
    .popValid(popValid), .popData(popData), .popChan(popChan), .fifoEmpty(fifoEmpty),
    .fifoFull(fifoFull), .overflow(overflow), .overflowClr(overflowClr));
  awr_conv_model u_awr_conv_model (.pins(pins), .code(code), .convNs(convNs), .doneN(doneN),
    .result_bus(result_bus));
  task automatic chk(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic pop_one(input logic [7:0] d, input logic [3:0] ch);
    popReq = 1'b1;
    @(negedge sys_clk) popReq = 1'b0;
    for (int i = 0; i < 3 && popValid !== 1'b1; i++) @(negedge sys_clk);
    chk(popValid === 1'b1 && popData === d && popChan === ch, "pop data or channel");
    // Let an edge pass so a following call never raises the request in this time step
    @(negedge sys_clk);
  endtask
  task automatic t_reset();
    chk(pins === 4'b1111 && muxChan === 4'h0 && fifoEmpty === 1'b1, "reset pins");
    chk(overflow === 1'b0 && fifoFull === 1'b0 && popValid === 1'b0, "reset flags");
    $display("reset test done");
  endtask
  // Slow answers must still be collected before the next start slot
  task automatic t_convert(input logic [7:0] c, input logic bip, input int ns);
    code = c;
    bipolar = bip;
    convNs = ns;
    for (int i = 0; i < 1500 && fifoEmpty !== 1'b0; i++) @(negedge sys_clk);
    pop_one(bip ? c ^ 8'h80 : c, expChan);
    chk(muxChan === expChan + 4'h1, "channel not advanced");
    expChan++;
    $display("convert test %h done", c);
  endtask
  task automatic t_overflow();
    for (int i = 0; i < 6000 && overflow !== 1'b1; i++) @(negedge sys_clk);
    chk(overflow === 1'b1 && fifoFull === 1'b1, "no overflow");
    for (int i = 0; i < 4; i++) pop_one(code ^ 8'h80, expChan + i[3:0]);
    chk(fifoEmpty === 1'b1 && overflow === 1'b1, "drain or sticky flag");
    overflowClr = 1'b1;
    @(negedge sys_clk) overflowClr = 1'b0;
    chk(overflow === 1'b0, "overflow not cleared");
    $display("overflow test done");
  endtask
  initial begin
    repeat (20) @(negedge sys_clk);
    t_reset();
    rst_n = 1'b1;
    enable = 1'b1;
    foreach (codes[k]) t_convert(codes[k], k[0], k == 3 ? 2001 : 381);
    t_overflow();
    give_verdict();
  end
  initial begin
    #200000;
    bad_count++;
    give_verdict();
  end
endmodule
